// ==== core/mprc_pkg.sv ====
/*
 * Constants for the port, reset and clock unit of a small 8-bit controller.
 * Assumes a single 200 MHz system clock standing in for the oscillator.
 */
`default_nettype none
package mprc_pkg;
	// ---------------------------------------------------------------
	// Port shapes
	// ---------------------------------------------------------------
	localparam int unsigned PORT_ONE_W   = 8;
	localparam int unsigned PORT_THREE_W = 8;
	localparam logic [7:0]  PORT_RESET   = 8'hff;
	localparam logic [7:0]  P1_PULLUP_MSK = 8'hfc;
	localparam logic [7:0]  P3_PIN_MSK   = 8'hbf;
	localparam int unsigned CMP_POS_BIT  = 0;
	localparam int unsigned CMP_NEG_BIT  = 1;
	localparam int unsigned CMP_OUT_BIT  = 6;
	localparam int unsigned RX_BIT       = 0;
	localparam int unsigned TX_BIT       = 1;
	localparam int unsigned IRQ0_BIT     = 2;
	localparam int unsigned IRQ1_BIT     = 3;
	localparam int unsigned TMR0_BIT     = 4;
	localparam int unsigned TMR1_BIT     = 5;
	// ---------------------------------------------------------------
	// Clocking
	// ---------------------------------------------------------------
	localparam int unsigned OSC_PER_MC   = 12;
	localparam int unsigned PH_PER_MC    = OSC_PER_MC / 2;
	localparam int unsigned RST_MC       = 2;
	localparam logic [3:0]  PH_LAST      = 4'(PH_PER_MC - 1);
	localparam logic [1:0]  RST_MC_LAST  = 2'(RST_MC - 1);

	typedef enum logic [2:0] {
		ST_RUN  = 3'b001,
		ST_IDLE = 3'b010,
		ST_PDN  = 3'b100
	} mprc_mode_t;
endpackage
`default_nettype wire

// ==== core/mprc_unit.sv ====
/*
 * Pin logic: two quasi-bidirectional ports, reset pin qualification,
 * oscillator divide-by-two and divide-by-twelve, idle and power-down.
 * Assumes the core writes latches on sys_clk and that pins are resolved
 * outside from the output enables (pins pulled high when not driven).
 */
`timescale 1ns/1ps
`default_nettype none

module mprc_unit (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       rst_pin,
	// Latch access from the core
	input  wire logic       p1_wr,
	input  wire logic [7:0] p1_wdata,
	input  wire logic       p3_wr,
	input  wire logic [7:0] p3_wdata,
	input  wire logic       tx_out,
	input  wire logic       cmp_result,
	// Mode requests
	input  wire logic       idle_req,
	input  wire logic       pdn_req,
	input  wire logic       irq_wake,
	input  wire logic       prog_mode,
	input  wire logic [7:0] prog_data_out,
	input  wire logic       prog_data_oe,
	// Pins
	input  wire logic [7:0] p1_in,
	output logic      [7:0] p1_out,
	output logic      [7:0] p1_oe,
	input  wire logic [7:0] p3_in,
	output logic      [7:0] p3_out,
	output logic      [7:0] p3_oe,
	// Reads and alternate functions
	output logic      [7:0] p1_rdata,
	output logic      [7:0] p3_rdata,
	output logic            cmp_in_pos,
	output logic            cmp_in_neg,
	output logic            serial_rx_in,
	output logic            ext_irq_zero,
	output logic            ext_irq_one,
	output logic            timer_zero_count_in,
	output logic            timer_one_count_in,
	output logic [7:0]      prog_data_in,
	output logic [5:0]      prog_ctrl_in,
	// Clocking and state
	output logic            half_clk_en,
	output logic            mc_en,
	output logic            cpu_run,
	output logic            periph_run,
	output logic            dev_reset
);
	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [7:0] p1_s1_q, p1_s2_q, p3_s1_q, p3_s2_q;
	logic       rp_s1_q, rp_s2_q;
	always_ff @(posedge sys_clk) begin
		p1_s1_q <= p1_in;
		p1_s2_q <= p1_s1_q;
		p3_s1_q <= p3_in;
		p3_s2_q <= p3_s1_q;
		rp_s1_q <= rst_pin;
		rp_s2_q <= rp_s1_q;
	end

	// ---------------------------------------------------------------
	// Clock division
	// ---------------------------------------------------------------
	logic       div2_q;
	logic [3:0] ph_q;
	mprc_pkg::mprc_mode_t mode_q;
	logic osc_on;
	assign osc_on = (mode_q != mprc_pkg::ST_PDN);
	// Enable pulses only; no derived clock, so duty cycle never matters
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			div2_q <= 1'b0;
			ph_q   <= 4'h0;
		end else if (osc_on) begin
			div2_q <= ~div2_q;
			if (div2_q)
				ph_q <= (ph_q == mprc_pkg::PH_LAST) ? 4'h0 : ph_q + 4'h1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			half_clk_en <= 1'b0;
			mc_en       <= 1'b0;
		end else begin
			half_clk_en <= osc_on & div2_q;
			mc_en       <= osc_on & div2_q & (ph_q == mprc_pkg::PH_LAST);
		end
	end

	// ---------------------------------------------------------------
	// Reset pin qualification
	// ---------------------------------------------------------------
	logic [1:0] rmc_q;
	logic       full_rst;
	logic       mc_tick;
	assign mc_tick  = osc_on & div2_q & (ph_q == mprc_pkg::PH_LAST);
	assign full_rst = rp_s2_q & mc_tick & (rmc_q == mprc_pkg::RST_MC_LAST);
	// Counts only with the oscillator running; power-down still escapes
	// because the pin wakes the oscillator first
	always_ff @(posedge sys_clk) begin
		if (!rstn || !rp_s2_q)
			rmc_q <= 2'h0;
		else if (mc_tick && rmc_q != mprc_pkg::RST_MC_LAST)
			rmc_q <= rmc_q + 2'h1;
	end
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			dev_reset <= 1'b1;
		else
			dev_reset <= full_rst | (dev_reset & rp_s2_q);
	end

	// ---------------------------------------------------------------
	// Modes
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rstn || full_rst) begin
			mode_q <= mprc_pkg::ST_RUN;
		end else begin
			unique case (mode_q)
				mprc_pkg::ST_RUN: begin
					if (pdn_req)
						mode_q <= mprc_pkg::ST_PDN;
					else if (idle_req)
						mode_q <= mprc_pkg::ST_IDLE;
				end
				mprc_pkg::ST_IDLE: begin
					if (irq_wake)
						mode_q <= mprc_pkg::ST_RUN;
				end
				mprc_pkg::ST_PDN: begin
					if (rp_s2_q)
						mode_q <= mprc_pkg::ST_RUN;
				end
				default: mode_q <= mprc_pkg::ST_RUN;
			endcase
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cpu_run    <= 1'b0;
			periph_run <= 1'b0;
		end else begin
			cpu_run    <= (mode_q == mprc_pkg::ST_RUN) & ~dev_reset;
			periph_run <= (mode_q != mprc_pkg::ST_PDN) & ~dev_reset;
		end
	end

	// ---------------------------------------------------------------
	// Port latches; static, held without any clock enable
	// ---------------------------------------------------------------
	// All eight port one bits sink alike; pullups on bits 0 and 1 are off chip
	logic [7:0] p1_lat_q, p3_lat_q;
	always_ff @(posedge sys_clk) begin
		if (!rstn || rp_s2_q) begin
			p1_lat_q <= mprc_pkg::PORT_RESET;
			p3_lat_q <= mprc_pkg::PORT_RESET;
		end else if (!prog_mode) begin
			if (p1_wr)
				p1_lat_q <= p1_wdata;
			if (p3_wr)
				p3_lat_q <= p3_wdata | ~mprc_pkg::P3_PIN_MSK;
		end
	end

	// ---------------------------------------------------------------
	// Pin drivers: quasi-bidirectional, drive low only on a zero; programming output drives port one both ways
	// ---------------------------------------------------------------
	logic [7:0] p3_eff;
	always_comb begin
		p3_eff = p3_lat_q;
		p3_eff[mprc_pkg::TX_BIT] = p3_lat_q[mprc_pkg::TX_BIT] & tx_out;
	end
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			p1_out <= 8'h00;
			p1_oe  <= 8'h00;
			p3_out <= 8'h00;
			p3_oe  <= 8'h00;
		end else begin
			if (prog_mode && prog_data_oe && !rp_s2_q) begin
				p1_out <= prog_data_out;
				p1_oe  <= 8'hff;
			end else begin
				p1_out <= 8'h00;
				p1_oe  <= rp_s2_q ? 8'h00 : ~p1_lat_q;
			end
			p3_out <= 8'h00;
			p3_oe  <= rp_s2_q ? 8'h00 : (~p3_eff & mprc_pkg::P3_PIN_MSK);
		end
	end

	// ---------------------------------------------------------------
	// Read paths and alternate inputs
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			p1_rdata            <= mprc_pkg::PORT_RESET;
			p3_rdata            <= mprc_pkg::PORT_RESET;
			cmp_in_pos          <= 1'b1;
			cmp_in_neg          <= 1'b1;
			serial_rx_in        <= 1'b1;
			ext_irq_zero        <= 1'b1;
			ext_irq_one         <= 1'b1;
			timer_zero_count_in <= 1'b1;
			timer_one_count_in  <= 1'b1;
			prog_data_in        <= 8'h00;
			prog_ctrl_in        <= 6'h00;
		end else begin
			// Zero latch pulls the pin low, so a read then shows zero
			p1_rdata <= p1_s2_q & p1_lat_q;
			p3_rdata <= (p3_s2_q & p3_eff & mprc_pkg::P3_PIN_MSK)
				| ({7'h00, cmp_result} << mprc_pkg::CMP_OUT_BIT);
			cmp_in_pos          <= p1_s2_q[mprc_pkg::CMP_POS_BIT];
			cmp_in_neg          <= p1_s2_q[mprc_pkg::CMP_NEG_BIT];
			serial_rx_in        <= p3_s2_q[mprc_pkg::RX_BIT];
			ext_irq_zero        <= p3_s2_q[mprc_pkg::IRQ0_BIT];
			ext_irq_one         <= p3_s2_q[mprc_pkg::IRQ1_BIT];
			timer_zero_count_in <= p3_s2_q[mprc_pkg::TMR0_BIT];
			timer_one_count_in  <= p3_s2_q[mprc_pkg::TMR1_BIT];
			prog_data_in        <= prog_mode ? p1_s2_q : 8'h00;
			prog_ctrl_in        <= prog_mode ? p3_s2_q[5:0] : 6'h00;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_pins_release_rst: assert property (@(posedge sys_clk) disable iff (!rstn)
		rp_s2_q |=> (p1_oe == 8'h00) && (p3_oe == 8'h00))
		else $error("pins driven while reset pin high");
	a_mc_spacing: assert property (@(posedge sys_clk) disable iff (!rstn)
		mc_en |=> !mc_en [*8])
		else $error("machine cycle too short");
	a_half_alt: assert property (@(posedge sys_clk) disable iff (!rstn)
		half_clk_en && osc_on |=> !half_clk_en)
		else $error("half clock enable not divided");
	a_reset_qual: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(dev_reset) |-> $past(rp_s2_q) && ($past(rmc_q) == mprc_pkg::RST_MC_LAST))
		else $error("full reset without two machine cycles");
	a_p6_input: assert property (@(posedge sys_clk) disable iff (!rstn)
		!p3_oe[mprc_pkg::CMP_OUT_BIT])
		else $error("comparator bit driven");
	a_p1_release: assert property (@(posedge sys_clk) disable iff (!rstn)
		p1_lat_q[2] && !prog_mode |=> !p1_oe[2])
		else $error("released bit still driven");
	a_idle_cpu: assert property (@(posedge sys_clk) disable iff (!rstn)
		mode_q == mprc_pkg::ST_IDLE |=> !cpu_run)
		else $error("cpu runs in idle");
	a_pdn_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
		mode_q == mprc_pkg::ST_PDN && !rp_s2_q |=> !half_clk_en && !periph_run)
		else $error("activity in power-down");
	c_full_reset: cover property (@(posedge sys_clk) $rose(dev_reset));
	c_idle_wake: cover property (@(posedge sys_clk) mode_q == mprc_pkg::ST_IDLE ##1 mode_q == mprc_pkg::ST_RUN);
	c_pdn: cover property (@(posedge sys_clk) mode_q == mprc_pkg::ST_PDN);
endmodule

`default_nettype wire

// ==== sim/mprc_pins_model.sv ====
/*
 * External circuitry on both ports: pullups and switches that pull pins low.
 * Assumes a high output enable means the device drives the pin.
 */
`timescale 1ns/1ps
`default_nettype none
module mprc_pins_model (
	// Device side
	input  wire logic [7:0] p1_out,
	input  wire logic [7:0] p1_oe,
	input  wire logic [7:0] p3_out,
	input  wire logic [7:0] p3_oe,
	// Switches, high pulls the pin low
	input  wire logic [7:0] sw1_low,
	input  wire logic [7:0] sw3_low,
	// Resolved pin levels
	output logic      [7:0] p1_in,
	output logic      [7:0] p3_in
);
	// Pullups on every undriven pin of both ports, no floating pins
	assign p1_in = (p1_oe & p1_out) | (~p1_oe & ~sw1_low);
	assign p3_in = (p3_oe & p3_out) | (~p3_oe & ~sw3_low);
endmodule
`default_nettype wire

// ==== sim/test_mprc_unit.sv ====
/*
 * Self-checking bench for the port, reset and clock unit.
 * Assumes the pin model resolves the pads; inputs change on falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
module test_mprc_unit;
	logic       sys_clk, rstn, rst_pin, p1_wr, p3_wr, tx_out, cmp_result;
	logic       idle_req, pdn_req, irq_wake, prog_mode, prog_data_oe;
	logic [7:0] p1_wdata, p3_wdata, prog_data_out, lo1, lo3, r, e1, e3;
	int         err_count, n_checks, i, k;
	wire  [7:0] p1_in, p3_in, p1_out, p1_oe, p3_out, p3_oe, p1_rdata, p3_rdata, pdi;
	wire  [5:0] pci;
	wire        c_pos, c_neg, rx, iq0, iq1, tc0, tc1, hce, mce, cpu_run, per_run, dev_reset;

	mprc_unit dut_u (.sys_clk(sys_clk), .rstn(rstn), .rst_pin(rst_pin), .p1_wr(p1_wr),
		.p1_wdata(p1_wdata), .p3_wr(p3_wr), .p3_wdata(p3_wdata), .tx_out(tx_out),
		.cmp_result(cmp_result), .idle_req(idle_req), .pdn_req(pdn_req), .irq_wake(irq_wake),
		.prog_mode(prog_mode), .prog_data_out(prog_data_out), .prog_data_oe(prog_data_oe),
		.p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe), .p3_in(p3_in), .p3_out(p3_out),
		.p3_oe(p3_oe), .p1_rdata(p1_rdata), .p3_rdata(p3_rdata), .cmp_in_pos(c_pos),
		.cmp_in_neg(c_neg), .serial_rx_in(rx), .ext_irq_zero(iq0), .ext_irq_one(iq1),
		.timer_zero_count_in(tc0), .timer_one_count_in(tc1), .prog_data_in(pdi),
		.prog_ctrl_in(pci), .half_clk_en(hce), .mc_en(mce), .cpu_run(cpu_run),
		.periph_run(per_run), .dev_reset(dev_reset));
	mprc_pins_model pins_u (.p1_out(p1_out), .p1_oe(p1_oe), .p3_out(p3_out), .p3_oe(p3_oe),
		.sw1_low(lo1), .sw3_low(lo3), .p1_in(p1_in), .p3_in(p3_in));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	// Port three latch after a write: bit 6 stuck high, bit 1 gated by transmit
	function automatic logic [7:0] p3_lat_exp(input logic [7:0] w, input logic tx);
		return (w & ~{6'h00, ~tx, 1'b0}) | 8'h40;
	endfunction
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask
	// Counts pulses of the clock enables over 120 clocks
	task automatic count_en(input logic [7:0] eh, input logic [7:0] em);
		logic [7:0] nh, nm;
		nh = 0;
		nm = 0;
		repeat (120) begin
			tick(1);
			nh += 8'(hce === 1'b1);
			nm += 8'(mce === 1'b1);
		end
		chk("half_clk_en", eh, nh);
		chk("mc_en", em, nm);
	endtask
	task automatic stop_test;
		if (err_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		sys_clk = 0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial begin
		#50000;
		err_count++;
		stop_test();
	end

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial begin
		{rstn, rst_pin, p1_wr, p3_wr, cmp_result, idle_req, pdn_req, irq_wake} = 0;
		{prog_mode, prog_data_oe, p1_wdata, p3_wdata, prog_data_out, lo1, lo3} = 0;
		tx_out = 1;
		err_count = 0;
		n_checks = 0;
		r = 8'h17;
		tick(10);
		rstn = 1;
		for (k = 0; k < 40 && dev_reset !== 1'b0; k++) tick(1);
		chk("dev_reset", 8'h00, {7'h00, dev_reset});
		tick(3);
		chk("p1_oe", 8'h00, p1_oe);
		chk("p1_rdata", 8'hff, p1_rdata);
		for (i = 0; i < 24; i++) begin
			r = lfsr(r);
			e1 = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : r;
			lo1 = lfsr(r) & ~{8{i < 2}};
			tx_out = r[2];
			cmp_result = r[5];
			lo3 = lfsr(lfsr(r));
			p1_wdata = ~e1;
			p1_wr = 1;
			tick(1);
			p1_wdata = e1;
			p3_wdata = ~r;
			p3_wr = 1;
			tick(1);
			{p1_wr, p3_wr} = 0;
			tick(5);
			e3 = p3_lat_exp(~r, tx_out);
			chk("p1_oe", ~e1, p1_oe);
			chk("p3_out", 8'h00, p3_out);
			chk("p1_out", 8'h00, p1_out);
			chk("p1_rdata", e1 & ~lo1, p1_rdata);
			chk("p3_oe", ~e3 & 8'hbf, p3_oe);
			e3 = e3 & ~lo3;
			e3[6] = cmp_result;
			chk("p3_rdata", e3, p3_rdata);
			chk("cmp_in", {6'h00, e1[1:0] & ~lo1[1:0]}, {6'h00, c_neg, c_pos});
			chk("alt", {2'b00, e3[5:2], 1'b0, e3[0]}, {2'b00, tc1, tc0, iq1, iq0, 1'b0, rx});
		end
		count_en(8'd60, 8'd10);
		pulse(idle_req);
		tick(3);
		chk("idle", 8'h01, {6'h00, cpu_run, per_run});
		count_en(8'd60, 8'd10);
		pulse(irq_wake);
		tick(3);
		chk("wake", 8'h03, {6'h00, cpu_run, per_run});
		// Short reset pulse: pins released at once, no full reset
		p1_wdata = 8'h00;
		pulse(p1_wr);
		tick(3);
		rst_pin = 1;
		tick(5);
		chk("p1_oe", 8'h00, p1_oe);
		chk("dev_reset", 8'h00, {7'h00, dev_reset});
		pulse(p1_wr);
		rst_pin = 0;
		tick(5);
		chk("p1_oe", 8'h00, p1_oe);
		pulse(pdn_req);
		tick(3);
		chk("pdn", 8'h00, {6'h00, cpu_run, per_run});
		count_en(8'd0, 8'd0);
		rst_pin = 1;
		for (k = 0; k < 80 && dev_reset !== 1'b1; k++) tick(1);
		chk("dev_reset", 8'h01, {7'h00, dev_reset});
		rst_pin = 0;
		for (k = 0; k < 40 && dev_reset !== 1'b0; k++) tick(1);
		chk("dev_reset", 8'h00, {7'h00, dev_reset});
		tick(3);
		chk("run", 8'h03, {6'h00, cpu_run, per_run});
		// Programming: pins seen through, latch writes dropped
		// Transmit idle high so port three bit 1 is released
		tx_out = 1;
		prog_mode = 1;
		p1_wdata = 8'h00;
		pulse(p1_wr);
		lo1 = 8'h5a;
		lo3 = 8'h2c;
		tick(5);
		chk("prog_data_in", 8'ha5, pdi);
		chk("prog_ctrl_in", 8'h13, {2'b00, pci});
		prog_data_out = 8'h9e;
		prog_data_oe = 1;
		tick(3);
		chk("p1_out", 8'h9e, p1_out);
		chk("p1_oe", 8'hff, p1_oe);
		{prog_data_oe, prog_mode, lo1} = 0;
		tick(5);
		chk("p1_oe", 8'h00, p1_oe);
		stop_test();
	end
endmodule
`default_nettype wire
